// *** src/nibble_controller.sv ***
// Nibble controller: control buses, strobe source borrowing, sample clock select
// Functional notes
// R01: Take 40-bit receive control bus per slice
// R02: Drive and take back 40-bit transmit buses
// R03: Separate 40-bit buses to/from tristate slice
// R04: Positive borrow true takes sibling positive strobe
// R05: Negative borrow true takes sibling negative strobe
// R06: Never borrow one polarity in both siblings
// R07: Serial mode samples with divided master clock
// R08: Non-serial mode samples with slice-zero strobe; code uses sibling's positive strobe when positive borrowing is on
// R09: Data-only streams should use serial mode
// R10: Settings readable and writable as register bits
// R11: Cross-wire internibble outputs to sibling inputs
// R12: Negative internibble input ignored unless borrowed
// R13: Clock settings frozen while interface active
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
`include "nibble_defs.svh"
module nibble_controller import nibble_pkg::*; #(
    parameter int NSLICE = `NSLICE_DEF,
    parameter int MASTER_DIV = `MASTER_DIV_DEF
) (
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    nibble_link_if.ctrl LINK,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic IF_ACTIVE_I,
    input wire ctrl_bus_t [NSLICE-1:0] TX_CTRL_I,
    input wire ctrl_bus_t TRI_CTRL_I,
    output ctrl_bus_t [NSLICE-1:0] RX_CTRL_O,
    output ctrl_bus_t [NSLICE-1:0] TX_RET_O,
    output ctrl_bus_t TRI_RET_O,
    output logic POS_STROBE_O,
    output logic NEG_STROBE_O,
    output logic SAMPLE_CLK_O
);
    wb_state_t wb_state_reg, wb_state_next;
    logic [31:0] dat_reg, dat_next;
    logic borrow_pos_reg, borrow_pos_next;
    logic borrow_neg_reg, borrow_neg_next;
    logic serial_reg, serial_next;
    logic refused_reg, refused_next;
    logic [`SYNC_W-1:0] sync1_reg, sync2_reg;
    logic [7:0] div_cnt_reg, div_cnt_next;
    logic master_clk_reg, master_clk_next;
    logic pos_reg, pos_next;
    logic neg_reg, neg_next;
    logic sample_reg, sample_next;
    logic own_pos_out_reg, own_neg_out_reg;
    ctrl_bus_t [NSLICE-1:0] tx_drv_reg, rx_ret_reg, tx_ret_reg;
    ctrl_bus_t tri_drv_reg, tri_ret_reg;
    logic req;
    logic wr_cfg;
    logic wr_status;

    // Bit order of the synchroniser vector
    localparam int S_PSTR = 0;
    localparam int S_NSTR = 1;
    localparam int S_PIN = 2;
    localparam int S_NIN = 3;

    function automatic logic [31:0] status_word(input logic act, input logic refu,
            input logic p, input logic n, input logic s, input logic m);
        logic [31:0] w;
        w = 32'h0;
        w[`ST_ACTIVE_BIT] = act;
        w[`ST_REFUSED_BIT] = refu;
        w[`ST_POS_BIT] = p;
        w[`ST_NEG_BIT] = n;
        w[`ST_SAMPLE_BIT] = s;
        w[`ST_MASTER_BIT] = m;
        return w;
    endfunction : status_word

    assign req = WB_CYC_I && WB_STB_I && (wb_state_reg == WB_IDLE);
    assign wr_cfg = (wb_state_reg == WB_ACK) && WB_CYC_I && WB_STB_I && WB_WE_I
        && (WB_ADR_I == `REG_CFG_OFS) && WB_SEL_I[0];
    assign wr_status = (wb_state_reg == WB_ACK) && WB_CYC_I && WB_STB_I && WB_WE_I
        && (WB_ADR_I == `REG_STATUS_OFS) && WB_SEL_I[0];

    always_comb begin
        wb_state_next = WB_IDLE;
        dat_next = dat_reg;
        if (req) begin
            wb_state_next = WB_ACK;
            // Unmapped offsets read as zero and still acknowledge
            case (WB_ADR_I)
                `REG_CFG_OFS: begin
                    dat_next = 32'h0;
                    dat_next[`CFG_BORROW_POS_BIT] = borrow_pos_reg; // R10
                    dat_next[`CFG_BORROW_NEG_BIT] = borrow_neg_reg; // R10
                    dat_next[`CFG_SERIAL_BIT] = serial_reg; // R10
                end
                `REG_STATUS_OFS: begin
                    dat_next = status_word(IF_ACTIVE_I, refused_reg, pos_reg, neg_reg,
                        sample_reg, serial_reg);
                end
                default: begin
                    dat_next = 32'h0;
                end
            endcase
        end

        borrow_pos_next = borrow_pos_reg;
        borrow_neg_next = borrow_neg_reg;
        serial_next = serial_reg;
        refused_next = refused_reg;
        if (wr_status && WB_DAT_I[`ST_REFUSED_BIT]) begin
            refused_next = 1'b0;
        end
        if (wr_cfg) begin
            if (IF_ACTIVE_I) begin
                // Switching a strobe source mid-burst would glitch the sample clock
                refused_next = 1'b1; // R13
            end else begin
                borrow_pos_next = WB_DAT_I[`CFG_BORROW_POS_BIT]; // R10
                borrow_neg_next = WB_DAT_I[`CFG_BORROW_NEG_BIT]; // R10
                serial_next = WB_DAT_I[`CFG_SERIAL_BIT]; // R10
            end
        end

        // Master clock stands in for the PLL or reference divided output
        div_cnt_next = div_cnt_reg + 8'h01;
        master_clk_next = master_clk_reg;
        if (div_cnt_reg >= 8'(MASTER_DIV - 1)) begin
            div_cnt_next = 8'h00;
            master_clk_next = ~master_clk_reg;
        end

        pos_next = borrow_pos_reg ? sync2_reg[S_PIN] : sync2_reg[S_PSTR]; // R04
        // Input stays unused unless borrowing is on
        neg_next = borrow_neg_reg ? sync2_reg[S_NIN] : sync2_reg[S_NSTR]; // R05 R12
        sample_next = serial_reg ? master_clk_reg : pos_reg; // R07 R08
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wb_state_reg <= WB_IDLE;
            dat_reg <= 32'h0;
            borrow_pos_reg <= 1'(`CFG_RESET >> `CFG_BORROW_POS_BIT);
            borrow_neg_reg <= 1'(`CFG_RESET >> `CFG_BORROW_NEG_BIT);
            serial_reg <= 1'(`CFG_RESET >> `CFG_SERIAL_BIT);
            refused_reg <= 1'b0;
            sync1_reg <= '0;
            sync2_reg <= '0;
            div_cnt_reg <= 8'h00;
            master_clk_reg <= 1'b0;
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
            sample_reg <= 1'b0;
            own_pos_out_reg <= 1'b0;
            own_neg_out_reg <= 1'b0;
            tx_drv_reg <= '0;
            rx_ret_reg <= '0;
            tx_ret_reg <= '0;
            tri_drv_reg <= '0;
            tri_ret_reg <= '0;
        end else begin
            wb_state_reg <= wb_state_next;
            dat_reg <= dat_next;
            borrow_pos_reg <= borrow_pos_next;
            borrow_neg_reg <= borrow_neg_next;
            serial_reg <= serial_next;
            refused_reg <= refused_next;
            sync1_reg <= {LINK.neg_internibble_in, LINK.pos_internibble_in,
                LINK.slice_zero_neg_strobe, LINK.slice_zero_pos_strobe};
            sync2_reg <= sync1_reg;
            div_cnt_reg <= div_cnt_next;
            master_clk_reg <= master_clk_next;
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            sample_reg <= sample_next;
            own_pos_out_reg <= sync2_reg[S_PSTR]; // R11
            own_neg_out_reg <= sync2_reg[S_NSTR]; // R11
            tx_drv_reg <= TX_CTRL_I; // R02
            rx_ret_reg <= LINK.slice_rx_ctrl_return; // R01
            tx_ret_reg <= LINK.slice_tx_ctrl_return; // R02
            tri_drv_reg <= TRI_CTRL_I; // R03
            tri_ret_reg <= LINK.tri_ctrl_return; // R03
        end
    end

    assign WB_ACK_O = (wb_state_reg == WB_ACK);
    assign WB_DAT_O = dat_reg;
    assign LINK.slice_tx_ctrl_drive = tx_drv_reg;
    assign LINK.tri_ctrl_drive = tri_drv_reg;
    assign LINK.pos_internibble_out = own_pos_out_reg;
    assign LINK.neg_internibble_out = own_neg_out_reg;
    assign LINK.sample_clock = sample_reg;
    assign LINK.sample_from_master = serial_reg;
    // Exported so the byte side can keep the sibling from borrowing the same polarity
    assign LINK.borrow_pos_cfg = borrow_pos_reg;
    assign LINK.borrow_neg_cfg = borrow_neg_reg;
    assign RX_CTRL_O = rx_ret_reg;
    assign TX_RET_O = tx_ret_reg;
    assign TRI_RET_O = tri_ret_reg;
    assign POS_STROBE_O = pos_reg;
    assign NEG_STROBE_O = neg_reg;
    assign SAMPLE_CLK_O = sample_reg;
endmodule : nibble_controller
`default_nettype wire

// *** include/nibble_defs.svh ***
// Offsets, field positions, reset values and counts of the nibble clock-select block
`ifndef NIBBLE_DEFS_SVH
`define NIBBLE_DEFS_SVH
`define CTRL_W 40
`define NSLICE_DEF 6
`define MASTER_DIV_DEF 2
`define REG_CFG_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define CFG_BORROW_POS_BIT 0
`define CFG_BORROW_NEG_BIT 1
`define CFG_SERIAL_BIT 2
`define CFG_RESET 3'h0
`define ST_ACTIVE_BIT 0
`define ST_REFUSED_BIT 1
`define ST_POS_BIT 2
`define ST_NEG_BIT 3
`define ST_SAMPLE_BIT 4
`define ST_MASTER_BIT 5
`define SYNC_W 4
`endif

// *** include/nibble_pkg.sv ***
// Types shared by both ends of the nibble link
`default_nettype none
package nibble_pkg;
    typedef logic [39:0] ctrl_bus_t;
    typedef enum logic [0:0] {WB_IDLE, WB_ACK} wb_state_t;
endpackage : nibble_pkg
`default_nettype wire

// *** include/nibble_link_if.sv ***
// Link between the nibble controller and its slices and sibling
`default_nettype none
interface nibble_link_if import nibble_pkg::*; #(parameter int NSLICE = 6);
    ctrl_bus_t [NSLICE-1:0] slice_rx_ctrl_return;
    ctrl_bus_t [NSLICE-1:0] slice_tx_ctrl_drive;
    ctrl_bus_t [NSLICE-1:0] slice_tx_ctrl_return;
    ctrl_bus_t tri_ctrl_drive;
    ctrl_bus_t tri_ctrl_return;
    logic slice_zero_pos_strobe;
    logic slice_zero_neg_strobe;
    logic pos_internibble_in;
    logic neg_internibble_in;
    logic pos_internibble_out;
    logic neg_internibble_out;
    logic sample_clock;
    logic sample_from_master;
    logic borrow_pos_cfg;
    logic borrow_neg_cfg;
    modport ctrl (
        input slice_rx_ctrl_return, slice_tx_ctrl_return, tri_ctrl_return,
        input slice_zero_pos_strobe, slice_zero_neg_strobe,
        input pos_internibble_in, neg_internibble_in,
        output slice_tx_ctrl_drive, tri_ctrl_drive,
        output pos_internibble_out, neg_internibble_out,
        output sample_clock, sample_from_master, borrow_pos_cfg, borrow_neg_cfg
    );
    modport far (
        output slice_rx_ctrl_return, slice_tx_ctrl_return, tri_ctrl_return,
        output slice_zero_pos_strobe, slice_zero_neg_strobe,
        output pos_internibble_in, neg_internibble_in,
        input slice_tx_ctrl_drive, tri_ctrl_drive,
        input pos_internibble_out, neg_internibble_out,
        input sample_clock, sample_from_master, borrow_pos_cfg, borrow_neg_cfg
    );
endinterface : nibble_link_if
`default_nettype wire

// *** src/slice_group.sv ***
// Far end: bit slices of the nibble plus the sibling controller of the byte
`default_nettype none
`include "nibble_defs.svh"
module slice_group import nibble_pkg::*; #(
    parameter int NSLICE = `NSLICE_DEF
) (
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    nibble_link_if.far LINK,
    input wire ctrl_bus_t [NSLICE-1:0] RX_CTRL_I,
    input wire ctrl_bus_t [NSLICE-1:0] TX_RET_I,
    input wire ctrl_bus_t TRI_RET_I,
    input wire logic SLICE0_POS_I,
    input wire logic SLICE0_NEG_I,
    input wire logic SIB_POS_STROBE_I,
    input wire logic SIB_NEG_STROBE_I,
    input wire logic SIB_BORROW_POS_REQ_I,
    input wire logic SIB_BORROW_NEG_REQ_I,
    input wire logic DATA_ONLY_I,
    output ctrl_bus_t [NSLICE-1:0] TX_CTRL_O,
    output ctrl_bus_t TRI_CTRL_O,
    output logic SAMPLE_CLK_O,
    output logic SAMPLE_FROM_MASTER_O,
    output logic SIB_POS_CLK_O,
    output logic SIB_NEG_CLK_O,
    output logic SIB_BORROW_POS_O,
    output logic SIB_BORROW_NEG_O,
    output logic BORROW_CONFLICT_O,
    output logic SERIAL_ADVISED_O
);
    ctrl_bus_t [NSLICE-1:0] rx_reg, txr_reg, txd_reg;
    ctrl_bus_t trir_reg, trid_reg;
    logic p0_reg, n0_reg, sibp_reg, sibn_reg;
    logic sample_reg, master_reg;
    logic sib_p_clk_reg, sib_n_clk_reg;
    logic grant_p_reg, grant_p_next;
    logic grant_n_reg, grant_n_next;
    logic conflict_reg, conflict_next;
    logic advise_reg;

    always_comb begin
        // Device claim wins; sibling request of the same polarity is dropped
        grant_p_next = SIB_BORROW_POS_REQ_I && !LINK.borrow_pos_cfg; // R06
        grant_n_next = SIB_BORROW_NEG_REQ_I && !LINK.borrow_neg_cfg; // R06
        conflict_next = (SIB_BORROW_POS_REQ_I && LINK.borrow_pos_cfg)
            || (SIB_BORROW_NEG_REQ_I && LINK.borrow_neg_cfg); // R06
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_reg <= '0;
            txr_reg <= '0;
            txd_reg <= '0;
            trir_reg <= '0;
            trid_reg <= '0;
            p0_reg <= 1'b0;
            n0_reg <= 1'b0;
            sibp_reg <= 1'b0;
            sibn_reg <= 1'b0;
            sample_reg <= 1'b0;
            master_reg <= 1'b0;
            sib_p_clk_reg <= 1'b0;
            sib_n_clk_reg <= 1'b0;
            grant_p_reg <= 1'b0;
            grant_n_reg <= 1'b0;
            conflict_reg <= 1'b0;
            advise_reg <= 1'b0;
        end else begin
            rx_reg <= RX_CTRL_I; // R01
            txr_reg <= TX_RET_I; // R02
            txd_reg <= LINK.slice_tx_ctrl_drive; // R02
            trir_reg <= TRI_RET_I; // R03
            trid_reg <= LINK.tri_ctrl_drive; // R03
            p0_reg <= SLICE0_POS_I;
            n0_reg <= SLICE0_NEG_I;
            sibp_reg <= SIB_POS_STROBE_I; // R11
            sibn_reg <= SIB_NEG_STROBE_I; // R11
            sample_reg <= LINK.sample_clock;
            master_reg <= LINK.sample_from_master;
            sib_p_clk_reg <= LINK.pos_internibble_out; // R11
            sib_n_clk_reg <= LINK.neg_internibble_out; // R11
            grant_p_reg <= grant_p_next;
            grant_n_reg <= grant_n_next;
            conflict_reg <= conflict_next;
            advise_reg <= DATA_ONLY_I; // R09
        end
    end

    assign LINK.slice_rx_ctrl_return = rx_reg;
    assign LINK.slice_tx_ctrl_return = txr_reg;
    assign LINK.tri_ctrl_return = trir_reg;
    assign LINK.slice_zero_pos_strobe = p0_reg;
    assign LINK.slice_zero_neg_strobe = n0_reg;
    assign LINK.pos_internibble_in = sibp_reg;
    assign LINK.neg_internibble_in = sibn_reg;
    assign TX_CTRL_O = txd_reg;
    assign TRI_CTRL_O = trid_reg;
    assign SAMPLE_CLK_O = sample_reg;
    assign SAMPLE_FROM_MASTER_O = master_reg;
    assign SIB_POS_CLK_O = sib_p_clk_reg;
    assign SIB_NEG_CLK_O = sib_n_clk_reg;
    assign SIB_BORROW_POS_O = grant_p_reg;
    assign SIB_BORROW_NEG_O = grant_n_reg;
    assign BORROW_CONFLICT_O = conflict_reg;
    assign SERIAL_ADVISED_O = advise_reg;
endmodule : slice_group
`default_nettype wire

// *** tb/nibble_clock_source_select_assertions.sv ***
// Concurrent checks on the nibble link and the selected strobe outputs
`default_nettype none
module nibble_clock_source_select_assertions #(
    parameter int MASTER_DIV = 2
) (
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    input wire logic borrow_pos_cfg,
    input wire logic borrow_neg_cfg,
    input wire logic sample_from_master,
    input wire logic sample_clock,
    input wire logic slice_zero_pos_strobe,
    input wire logic slice_zero_neg_strobe,
    input wire logic pos_internibble_in,
    input wire logic neg_internibble_in,
    input wire logic pos_internibble_out,
    input wire logic neg_internibble_out,
    input wire logic POS_STROBE_O,
    input wire logic NEG_STROBE_O,
    input wire logic SAMPLE_CLK_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_reg, cnt_next;
    logic last_reg, last_next;
    logic [1:0] seen_reg, seen_next;
    always_comb begin
        last_next = sample_clock;
        cnt_next = (sample_clock != last_reg) ? 8'h00 : cnt_reg + 8'h01;
        // Mode switch and first master toggle both have arbitrary spacing
        seen_next = seen_reg;
        if (!sample_from_master) begin
            seen_next = 2'h0;
        end else if ((sample_clock != last_reg) && (seen_reg != 2'h2)) begin
            seen_next = seen_reg + 2'h1;
        end
    end
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cnt_reg <= 8'h00;
            last_reg <= 1'b0;
            seen_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_next;
            last_reg <= last_next;
            seen_reg <= seen_next;
        end
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence s_serial_edge;
        sample_from_master && (seen_reg == 2'h2) && (sample_clock != last_reg);
    endsequence
    a_pos_own_strobe: assert property (!borrow_pos_cfg && !$past(borrow_pos_cfg, 3)
        |-> POS_STROBE_O == $past(slice_zero_pos_strobe, 3)) else $error("pos strobe not own");
    a_pos_borrow_strobe: assert property (borrow_pos_cfg && $past(borrow_pos_cfg, 3)
        |-> POS_STROBE_O == $past(pos_internibble_in, 3)) else $error("pos strobe not sibling");
    a_neg_own_strobe: assert property (!borrow_neg_cfg && !$past(borrow_neg_cfg, 3)
        |-> NEG_STROBE_O == $past(slice_zero_neg_strobe, 3)) else $error("neg strobe not own");
    a_neg_borrow_strobe: assert property (borrow_neg_cfg && $past(borrow_neg_cfg, 3)
        |-> NEG_STROBE_O == $past(neg_internibble_in, 3)) else $error("neg strobe not sibling");
    // Slice-zero strobe of the nibble, or the sibling's when positive borrowing is on
    a_sample_from_slice: assert property (!sample_from_master && !$past(sample_from_master)
        |-> SAMPLE_CLK_O == $past(POS_STROBE_O)) else $error("sample not slice strobe");
    a_serial_half_period: assert property (s_serial_edge |-> cnt_reg == MASTER_DIV - 1)
        else $error("serial sample clock half period wrong");
    a_pos_out_forward: assert property (pos_internibble_out == $past(slice_zero_pos_strobe, 3))
        else $error("pos internibble out wrong");
    a_neg_out_forward: assert property (neg_internibble_out == $past(slice_zero_neg_strobe, 3))
        else $error("neg internibble out wrong");
endmodule : nibble_clock_source_select_assertions
`default_nettype wire

// *** tb/nibble_clock_source_select_test.sv ***
// Self-checking bench for the nibble controller facing its slice group
`default_nettype none
`include "nibble_defs.svh"
module nibble_clock_source_select_test import nibble_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NSLICE = 6;
    localparam int MASTER_DIV = 2;
    logic clk, rst_n, cyc, stb, we, ack, if_active;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, rd;
    logic [3:0] sel;
    ctrl_bus_t [NSLICE-1:0] tx_ctrl, rx_ctrl, tx_ret, rx_out, tx_ret_out, tx_ctrl_out;
    ctrl_bus_t tri_ctrl, tri_ret, tri_ret_out, tri_ctrl_out;
    logic pos_o, neg_o, samp_o, samp_far, from_master, sib_pos_clk, sib_neg_clk;
    logic grant_pos, grant_neg, conflict, advised;
    logic s0_pos, s0_neg, sib_pos, sib_neg, req_pos, req_neg, data_only;
    int failures, compares, toggles;
    logic prev;
    nibble_link_if #(.NSLICE(NSLICE)) nibble_link_if_i ();
    nibble_controller #(.NSLICE(NSLICE), .MASTER_DIV(MASTER_DIV)) nibble_controller_i (
        .SYS_CLK_I(clk), .ARST_N_I(rst_n), .LINK(nibble_link_if_i),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(sel), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IF_ACTIVE_I(if_active),
        .TX_CTRL_I(tx_ctrl), .TRI_CTRL_I(tri_ctrl), .RX_CTRL_O(rx_out), .TX_RET_O(tx_ret_out),
        .TRI_RET_O(tri_ret_out), .POS_STROBE_O(pos_o), .NEG_STROBE_O(neg_o),
        .SAMPLE_CLK_O(samp_o));
    slice_group #(.NSLICE(NSLICE)) slice_group_i (
        .SYS_CLK_I(clk), .ARST_N_I(rst_n), .LINK(nibble_link_if_i),
        .RX_CTRL_I(rx_ctrl), .TX_RET_I(tx_ret), .TRI_RET_I(tri_ret),
        .SLICE0_POS_I(s0_pos), .SLICE0_NEG_I(s0_neg), .SIB_POS_STROBE_I(sib_pos),
        .SIB_NEG_STROBE_I(sib_neg), .SIB_BORROW_POS_REQ_I(req_pos),
        .SIB_BORROW_NEG_REQ_I(req_neg), .DATA_ONLY_I(data_only), .TX_CTRL_O(tx_ctrl_out),
        .TRI_CTRL_O(tri_ctrl_out), .SAMPLE_CLK_O(samp_far), .SAMPLE_FROM_MASTER_O(from_master),
        .SIB_POS_CLK_O(sib_pos_clk), .SIB_NEG_CLK_O(sib_neg_clk), .SIB_BORROW_POS_O(grant_pos),
        .SIB_BORROW_NEG_O(grant_neg), .BORROW_CONFLICT_O(conflict),
        .SERIAL_ADVISED_O(advised));
    nibble_clock_source_select_assertions #(.MASTER_DIV(MASTER_DIV)) checker_i (
        .SYS_CLK_I(clk), .ARST_N_I(rst_n),
        .borrow_pos_cfg(nibble_link_if_i.borrow_pos_cfg),
        .borrow_neg_cfg(nibble_link_if_i.borrow_neg_cfg),
        .sample_from_master(nibble_link_if_i.sample_from_master),
        .sample_clock(nibble_link_if_i.sample_clock),
        .slice_zero_pos_strobe(nibble_link_if_i.slice_zero_pos_strobe),
        .slice_zero_neg_strobe(nibble_link_if_i.slice_zero_neg_strobe),
        .pos_internibble_in(nibble_link_if_i.pos_internibble_in),
        .neg_internibble_in(nibble_link_if_i.neg_internibble_in),
        .pos_internibble_out(nibble_link_if_i.pos_internibble_out),
        .neg_internibble_out(nibble_link_if_i.neg_internibble_out),
        .POS_STROBE_O(pos_o), .NEG_STROBE_O(neg_o), .SAMPLE_CLK_O(samp_o));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Classic single cycle; the answer is awaited, never assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            $display("[ERR] %0t bus answer timed out", $time);
            give_verdict();
        end
    endtask : wb
    initial begin
        failures = 0;
        compares = 0;
        {rst_n, cyc, stb, we, if_active, s0_pos, s0_neg, sib_pos, sib_neg} = '0;
        {req_pos, req_neg, data_only, adr, wdat, sel} = '0;
        {tx_ctrl, rx_ctrl, tx_ret, tri_ctrl, tri_ret} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, `REG_CFG_OFS, 32'h0, 4'hf, rd);
        check(rd, 40'h0);
        for (int i = 0; i < NSLICE; i++) begin
            rx_ctrl[i] <= 40'ha1_5a5a_0000 + 40'(i);
            tx_ctrl[i] <= 40'hb2_a5a5_0000 + 40'(i);
            tx_ret[i] <= 40'hc3_0ff0_0000 + 40'(i);
        end
        tri_ctrl <= 40'hd4_1234_5678;
        tri_ret <= 40'he5_8765_4321;
        repeat (3) @(posedge clk);
        for (int i = 0; i < NSLICE; i++) begin
            check(rx_out[i], 40'ha1_5a5a_0000 + 40'(i));
            check(tx_ctrl_out[i], 40'hb2_a5a5_0000 + 40'(i));
            check(tx_ret_out[i], 40'hc3_0ff0_0000 + 40'(i));
        end
        check(tri_ctrl_out, 40'hd4_1234_5678);
        check(tri_ret_out, 40'he5_8765_4321);
        {s0_pos, s0_neg, sib_pos, sib_neg, req_pos, req_neg} <= 6'b100111;
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `REG_CFG_OFS, 32'(c), 4'hf, rd);
            repeat (6) @(posedge clk);
            check(pos_o, !c[0]);
            check(neg_o, c[1]);
            check(grant_pos, !c[0]);
            check(grant_neg, !c[1]);
            check(conflict, c[0] | c[1]);
            wb(1'b0, `REG_STATUS_OFS, 32'h0, 4'hf, rd);
            check(rd[4:2], {!c[0], c[1], !c[0]});
        end
        wb(1'b1, `REG_CFG_OFS, 32'h0, 4'hf, rd);
        for (int v = 1; v >= 0; v--) begin
            {s0_pos, s0_neg} <= {v[0], v[0]};
            repeat (8) @(posedge clk);
            check({samp_o, samp_far, from_master}, {v[0], v[0], 1'b0});
            check({sib_pos_clk, sib_neg_clk}, {v[0], v[0]});
            check(neg_o, v[0]);
        end
        wb(1'b1, `REG_CFG_OFS, 32'h4, 4'hf, rd);
        repeat (8) @(posedge clk);
        toggles = 0;
        prev = samp_o;
        repeat (40) begin
            @(posedge clk);
            if (samp_o !== prev) toggles++;
            prev = samp_o;
        end
        check(toggles, 40 / MASTER_DIV);
        check(from_master, 1'b1);
        if_active <= 1'b1;
        wb(1'b1, `REG_CFG_OFS, 32'h3, 4'hf, rd);
        wb(1'b0, `REG_CFG_OFS, 32'h0, 4'hf, rd);
        check(rd[2:0], 3'h4);
        wb(1'b0, `REG_STATUS_OFS, 32'h0, 4'hf, rd);
        // Sample bit toggles freely in serial mode, so it is left out here
        check({rd[5], rd[3:0]}, 5'h13);
        wb(1'b1, `REG_STATUS_OFS, 32'h2, 4'hf, rd);
        if_active <= 1'b0;
        wb(1'b0, `REG_STATUS_OFS, 32'h0, 4'hf, rd);
        check(rd[1:0], 2'b00);
        wb(1'b1, `REG_CFG_OFS, 32'h1, 4'he, rd);
        wb(1'b1, 8'h10, 32'h7, 4'hf, rd);
        wb(1'b0, 8'h10, 32'h0, 4'hf, rd);
        check(rd, 40'h0);
        wb(1'b0, `REG_CFG_OFS, 32'h0, 4'hf, rd);
        check(rd[2:0], 3'h4);
        data_only <= 1'b1;
        repeat (3) @(posedge clk);
        check(advised, 1'b1);
        give_verdict();
    end
endmodule : nibble_clock_source_select_test
`default_nettype wire
